/* File: verilog/sar_pkg.sv */
// shared constants for the successive approximation control logic
package sar_pkg;
    // *****************************************************************
    // widths and lengths
    // *****************************************************************
    localparam int          LATCH_WIDTH     = 16;
    localparam int          BASE_LENGTH     = 8;
    localparam int          MIN_LENGTH      = 9;
    localparam int          MAX_LENGTH      = 15;
    localparam int          SEL_WIDTH       = 4;
    localparam int          FIFO_DEPTH      = 32;
    // core clocks per converter period
    localparam int          STEP_CYCLES     = 4;
    // *****************************************************************
    // reset values
    // *****************************************************************
    localparam logic [15:0] LATCH_RESET     = 16'h0000;
    localparam logic [4:0]  COUNT_RESET     = 5'h00;
    localparam logic [3:0]  SEL_8BIT        = 4'h0;
    // *****************************************************************
    // sequencer states
    // *****************************************************************
    typedef enum logic [1:0] {
        ST_CLEAR,
        ST_TRIAL,
        ST_END
    } seq_state_type;
endpackage

/* File: verilog/sar_result_fifo.sv */
// parameterised result fifo with valid and ready on both sides
`timescale 1ns/1ps
module sar_result_fifo
    import sar_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             srst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two, at least 2");
    end

    // *****************************************************************
    // storage and pointers
    // *****************************************************************
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0]      wr_reg;
    logic [AW:0]      wr_next;
    logic [AW:0]      rd_reg;
    logic [AW:0]      rd_next;
    logic             push;
    logic             pop;
    logic             full;
    logic             empty;

    always_comb begin
        full    = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
        empty   = (wr_reg == rd_reg);
        push    = in_valid && !full;
        pop     = out_ready && !empty;
        wr_next = push ? wr_reg + 1'b1 : wr_reg;
        rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
        if (push) begin
            mem_reg[wr_reg[AW-1:0]] <= in_data;
        end
    end

    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_reg[rd_reg[AW-1:0]];
endmodule // sar_result_fifo

/* File: verilog/sar_addr_latch.sv */
// addressable result latch with clear mode
`timescale 1ns/1ps
module sar_addr_latch
    import sar_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     srst,
    // mode and data
    input  wire logic                     clear_mode,
    input  wire logic                     load_en,
    input  wire logic [$clog2(WIDTH)-1:0] addr,
    input  wire logic                     data_in,
    // latch contents
    output logic      [WIDTH-1:0]         q
);
    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;

    if (WIDTH < 2) begin : g_bad_width
        $error("latch width too small");
    end

    // *****************************************************************
    // per-bit load
    // *****************************************************************
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_comb begin
                if (clear_mode) begin
                    q_next[i] = 1'b0;
                end else if (load_en && addr == i) begin
                    q_next[i] = data_in;
                end else begin
                    q_next[i] = q_reg[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (srst) begin
            q_reg <= LATCH_RESET[WIDTH-1:0];
        end else begin
            q_reg <= q_next;
        end
    end

    assign q = q_reg;
endmodule // sar_addr_latch

/* File: verilog/sar_adc_control_logic.sv */
// sequencing logic of the successive approximation converter
`timescale 1ns/1ps
// Overview of operation
// - an 8-bit conversion takes 16 clock periods, msb first down to lsb.
// - even periods force the bit under trial to one, odd periods decide it.
// - the trial bit is cleared when the dac value exceeds the input, else kept.
// - after 16 periods the result is final and the terminal count follows.
// - the result also leaves serially on a clock at half the input rate.
// - a decision stage takes one compare per two periods and drives serial out.
// - the terminal count is delayed one clock and then clears the latches.
// - the programmable length picks 9 to 15 bits from a four-bit code.
// - the programmable latch is 16 bits and a shift stage is the counter lsb.
// - the programmable result is given in parallel and serially.
// - the asymmetric clock is kept in step with the counter's first stage.
// - in latch mode only the addressed latch loads, others hold.
// - in clear mode all latch outputs are low whatever the inputs.
module sar_adc_control_logic
    import sar_pkg::*;
(
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   srst,
    // analog side
    input  wire logic                   comp_above,
    output logic      [LATCH_WIDTH-1:0] dac_bits,
    // length select, 0 means 8 bits
    input  wire logic [SEL_WIDTH-1:0]   word_length_select,
    // status toward the clock generator
    output logic                        phase_odd,
    output logic                        cycle_end_count,
    // serial result
    output logic                        serial_data,
    output logic                        serial_clk,
    // parallel result stream
    output logic                        result_valid,
    input  wire logic                   result_ready,
    output logic      [LATCH_WIDTH-1:0] result_data,
    output logic                        result_overrun
);
    // period must leave room for the two synchroniser stages
    if (STEP_CYCLES < 3 || STEP_CYCLES > 256) begin : g_bad_step
        $error("period must span 3 to 256 clocks");
    end

    // *****************************************************************
    // input synchronisers
    // *****************************************************************
    logic                 comp_s1_reg;
    logic                 comp_s2_reg;
    logic [SEL_WIDTH-1:0] sel_s1_reg;
    logic [SEL_WIDTH-1:0] sel_s2_reg;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            comp_s1_reg <= 1'b0;
            comp_s2_reg <= 1'b0;
            sel_s1_reg  <= SEL_8BIT;
            sel_s2_reg  <= SEL_8BIT;
        end else begin
            comp_s1_reg <= comp_above;
            comp_s2_reg <= comp_s1_reg;
            sel_s1_reg  <= word_length_select;
            sel_s2_reg  <= sel_s1_reg;
        end
    end

    // *****************************************************************
    // length decode
    // *****************************************************************
    function automatic logic [4:0] length_of(input logic [SEL_WIDTH-1:0] code);
        logic [4:0] len;
        len = 5'(BASE_LENGTH);
        if (code >= SEL_WIDTH'(MIN_LENGTH) && code <= SEL_WIDTH'(MAX_LENGTH)) begin
            len = {1'b0, code};
        end
        return len;
    endfunction

    // *****************************************************************
    // period divider, one enable pulse per converter period
    // *****************************************************************
    logic [7:0]       div_reg;
    logic [7:0]       div_next;
    logic             step_en;

    always_comb begin
        step_en  = (div_reg == 8'(STEP_CYCLES - 1));
        div_next = step_en ? 8'h00 : div_reg + 8'h01;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_next;
        end
    end

    // *****************************************************************
    // counter and sequencer
    // *****************************************************************
    seq_state_type    state_reg;
    seq_state_type    state_next;
    logic [4:0]       bit_cnt_reg;
    logic [4:0]       bit_cnt_next;
    logic             phase_reg;
    logic             phase_next;
    logic [4:0]       len_reg;
    logic [4:0]       len_next;
    logic             decide_reg;
    logic             decide_next;
    logic             end_reg;
    logic             end_next;
    logic             end_dly_reg;
    logic             end_dly_next;
    logic [3:0]       addr;
    logic             latch_load;
    logic             latch_data;
    logic [LATCH_WIDTH-1:0] latch_q;

    always_comb begin
        state_next   = state_reg;
        bit_cnt_next = bit_cnt_reg;
        phase_next   = phase_reg;
        len_next     = len_reg;
        decide_next  = decide_reg;
        end_next     = 1'b0;
        end_dly_next = end_dly_reg;
        latch_load   = 1'b0;
        latch_data   = 1'b0;
        addr         = 4'(len_reg - 5'd1 - bit_cnt_reg);
        if (step_en) begin
            case (state_reg)
                ST_CLEAR: begin
                    len_next     = length_of(sel_s2_reg);
                    bit_cnt_next = COUNT_RESET;
                    phase_next   = 1'b0;
                    state_next   = ST_TRIAL;
                end
                ST_TRIAL: begin
                    phase_next   = ~phase_reg;
                    latch_load   = 1'b1;
                    end_dly_next = 1'b0;
                    if (!phase_reg) begin
                        latch_data = 1'b1;
                    end else begin
                        latch_data  = ~comp_s2_reg;
                        decide_next = ~comp_s2_reg;
                        if (bit_cnt_reg == len_reg - 5'd1) begin
                            end_next     = 1'b1;
                            end_dly_next = 1'b1;
                            bit_cnt_next = COUNT_RESET;
                            len_next     = length_of(sel_s2_reg);
                        end else begin
                            bit_cnt_next = bit_cnt_reg + 5'd1;
                        end
                    end
                end
                ST_END: begin
                    state_next = ST_CLEAR;
                end
                default: begin
                    state_next = ST_CLEAR;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_reg   <= ST_CLEAR;
            bit_cnt_reg <= COUNT_RESET;
            phase_reg   <= 1'b0;
            len_reg     <= 5'(BASE_LENGTH);
            decide_reg  <= 1'b0;
            end_reg     <= 1'b0;
            end_dly_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            phase_reg   <= phase_next;
            len_reg     <= len_next;
            decide_reg  <= decide_next;
            end_reg     <= end_next;
            end_dly_reg <= end_dly_next;
        end
    end

    // *****************************************************************
    // result latch
    // *****************************************************************
    sar_addr_latch #(
        .WIDTH      (LATCH_WIDTH)
    ) u_latch (
        .core_clk   (core_clk),
        .srst       (srst),
        .clear_mode (end_dly_reg && !latch_load),
        .load_en    (latch_load),
        .addr       (addr),
        .data_in    (latch_data),
        .q          (latch_q)
    );

    // *****************************************************************
    // parallel result fifo
    // *****************************************************************
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [LATCH_WIDTH-1:0] fifo_out_data;
    logic [LATCH_WIDTH-1:0] rdata_reg;
    logic [LATCH_WIDTH-1:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic ovr_reg;
    logic ovr_next;
    logic fifo_pop;

    sar_result_fifo #(
        .WIDTH      (LATCH_WIDTH),
        .DEPTH      (FIFO_DEPTH)
    ) u_fifo (
        .core_clk   (core_clk),
        .srst       (srst),
        .in_valid   (end_reg),
        .in_ready   (fifo_in_ready),
        .in_data    (latch_q),
        .out_valid  (fifo_out_valid),
        .out_ready  (fifo_pop),
        .out_data   (fifo_out_data)
    );

    always_comb begin
        fifo_pop    = fifo_out_valid && (!rvalid_reg || result_ready);
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        ovr_next    = ovr_reg || (end_reg && !fifo_in_ready);
        if (fifo_pop) begin
            rvalid_next = 1'b1;
            rdata_next  = fifo_out_data;
        end else if (result_ready) begin
            rvalid_next = 1'b0;
        end
    end

    // *****************************************************************
    // serial output, one bit per two periods
    // *****************************************************************
    logic sclk_reg;
    logic sclk_next;
    logic sdata_reg;
    logic sdata_next;
    logic tc_out_reg;

    always_comb begin
        sclk_next  = (state_reg == ST_TRIAL) && !phase_next;
        sdata_next = decide_next;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= LATCH_RESET;
            ovr_reg    <= 1'b0;
            sclk_reg   <= 1'b0;
            sdata_reg  <= 1'b0;
            tc_out_reg <= 1'b0;
        end else begin
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            ovr_reg    <= ovr_next;
            sclk_reg   <= sclk_next;
            sdata_reg  <= sdata_next;
            tc_out_reg <= end_next;
        end
    end

    assign dac_bits        = latch_q;
    assign phase_odd       = phase_reg;
    assign cycle_end_count = tc_out_reg;
    assign serial_data     = sdata_reg;
    assign serial_clk      = sclk_reg;
    assign result_valid    = rvalid_reg;
    assign result_data     = rdata_reg;
    assign result_overrun  = ovr_reg;
endmodule // sar_adc_control_logic

/* File: test/sar_adc_control_sva.sv */
// assertion checker for the converter sequencing ports
`timescale 1ns/1ps
module sar_adc_control_sva
    import sar_pkg::*;
(
    // clock and reset
    input wire logic                   core_clk,
    input wire logic                   srst,
    // analog side and status
    input wire logic                   comp_above,
    input wire logic [LATCH_WIDTH-1:0] dac_bits,
    input wire logic                   cycle_end_count,
    // serial and parallel results
    input wire logic                   serial_data,
    input wire logic                   serial_clk,
    input wire logic                   result_valid,
    input wire logic                   result_ready,
    input wire logic [LATCH_WIDTH-1:0] result_data,
    input wire logic                   result_overrun
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    sequence s_bit_cleared;
        (dac_bits != 16'h0000) && (($past(dac_bits) & ~dac_bits) != 16'h0000);
    endsequence
    property p_end_pulse;
        cycle_end_count |=> !cycle_end_count [*8];
    endproperty
    property p_end_clears;
        cycle_end_count |-> ##[1:2] (dac_bits == 16'h0000);
    endproperty
    property p_one_step;
        (dac_bits != 16'h0000) && !$stable(dac_bits) |-> $onehot(dac_bits ^ $past(dac_bits));
    endproperty
    property p_clear_cause;
        s_bit_cleared |-> $past(comp_above, 1) || $past(comp_above, 2)
            || $past(comp_above, 3) || $past(comp_above, 4);
    endproperty
    property p_one_decision;
        s_bit_cleared |=> not s_bit_cleared;
    endproperty
    property p_top_bit;
        dac_bits[15] == 1'b0;
    endproperty
    property p_serial_step;
        !$stable(serial_data) |-> $rose(serial_clk);
    endproperty
    property p_hold;
        result_valid && !result_ready |=> result_valid && $stable(result_data);
    endproperty
    property p_sticky;
        result_overrun |=> result_overrun;
    endproperty
    a_end_pulse: assert property (p_end_pulse) else $error("end count not a lone pulse");
    a_end_clears: assert property (p_end_clears) else $error("latch not cleared");
    a_one_step: assert property (p_one_step) else $error("latch moved >1 bit");
    a_clear_cause: assert property (p_clear_cause) else $error("clear w/o compare");
    a_one_decision: assert property (p_one_decision) else $error("two decisions");
    a_top_bit: assert property (p_top_bit) else $error("bit 15 used");
    a_serial_step: assert property (p_serial_step) else $error("serial bit w/o clock");
    a_hold: assert property (p_hold) else $error("result dropped while stalled");
    a_sticky: assert property (p_sticky) else $error("overrun flag fell");
endmodule // sar_adc_control_sva
bind sar_adc_control_logic sar_adc_control_sva chk (.core_clk, .srst, .comp_above, .dac_bits,
    .cycle_end_count, .serial_data, .serial_clk, .result_valid, .result_ready, .result_data,
    .result_overrun);

/* File: test/sar_analog_model.sv */
// behavioural dac network and comparator facing the converter
`timescale 1ns/1ps
module sar_analog_model
    import sar_pkg::*;
(
    // latch contents and input level
    input  wire logic [LATCH_WIDTH-1:0] dac_bits,
    input  wire logic [LATCH_WIDTH-1:0] vin_level,
    // comparator
    output logic                        comp_above
);
    // settles within two core clocks, well inside the converter period
    assign #150 comp_above = (dac_bits > vin_level);
endmodule // sar_analog_model

/* File: test/sar_adc_control_logic_bench.sv */
// self-checking bench for the converter sequencing logic
`timescale 1ns/1ps
module sar_adc_control_logic_bench import sar_pkg::*;;
    typedef struct {logic skip; logic [15:0] val; int n;} note_type;
    logic                   core_clk, srst, result_ready, comp_above, phase_odd;
    logic                   cycle_end_count, serial_data, serial_clk, sclk_prev;
    logic                   result_valid, result_overrun;
    logic [SEL_WIDTH-1:0]   word_length_select;
    logic [LATCH_WIDTH-1:0] dac_bits, result_data, vin_level, sreg, m;
    note_type               par_q[$], ser_q[$], nt;
    int                     num_errors, checks, seed, last_t, n_beats, cur_n, rdy_mode;

    sar_adc_control_logic uut (.core_clk, .srst, .comp_above, .dac_bits,
        .word_length_select, .phase_odd, .cycle_end_count, .serial_data, .serial_clk,
        .result_valid, .result_ready, .result_data, .result_overrun);
    sar_analog_model dac (.dac_bits, .vin_level, .comp_above);

    // ****************************************
    // clock and tasks
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wait_end();
        int k;
        k = 0;
        @(negedge core_clk);
        while (cycle_end_count !== 1'b1 && k < 200) begin
            @(negedge core_clk);
            k++;
        end
        if (k >= 200) begin
            num_errors++;
            $display("[ERR] %0t no end of cycle", $time);
        end
    endtask
    task automatic push(input logic s, input int n, input logic [15:0] v);
        par_q.push_back('{s, v, n});
        ser_q.push_back('{s, v, n});
    endtask

    // ****************************************
    // stimulus
    // ****************************************
    always @(negedge core_clk) begin
        if (rdy_mode == 0) begin
            result_ready <= 1'($random(seed));
        end else begin
            result_ready <= (rdy_mode == 2);
        end
    end
    initial begin
        int c, k;
        seed = 32'h1516;
        rdy_mode = 0;
        srst = 1'b1;
        result_ready = 1'b0;
        sclk_prev = 1'b0;
        sreg = 16'h0000;
        cur_n = BASE_LENGTH;
        word_length_select = SEL_8BIT;
        vin_level = 16'h005a;
        push(1'b0, 0, 16'h005a);
        repeat (6) @(negedge core_clk);
        srst = 1'b0;
        for (c = 0; c < 16; c++) begin
            wait_end();
            cur_n = (c >= MIN_LENGTH) ? c : BASE_LENGTH;
            word_length_select = c[3:0];
            push(1'b1, cur_n, 16'h0000);
            wait_end();
            m = 16'((1 << cur_n) - 1);
            vin_level = (c % 4 == 0) ? m : (c % 4 == 1) ? 16'h0000 : 16'($random(seed)) & m;
            push(1'b0, cur_n, vin_level);
        end
        rdy_mode = 2;
        for (k = 0; k < 500 && par_q.size() != 0; k++) @(negedge core_clk);
        check(16'(result_overrun), 16'h0000, "overrun early");
        rdy_mode = 1;
        repeat (FIFO_DEPTH + 3) wait_end();
        check(16'(result_overrun), 16'h0001, "overrun missing");
        n_beats = 0;
        rdy_mode = 2;
        repeat (80) @(negedge core_clk);
        check(16'(n_beats >= FIFO_DEPTH && n_beats <= FIFO_DEPTH + 4), 16'h0001, "drain count");
        results();
    end

    // ****************************************
    // result monitor
    // ****************************************
    always begin
        @(negedge core_clk);
        #1;
        if (srst === 1'b0) begin
            if (result_valid === 1'b1 && result_ready === 1'b1) begin
                n_beats++;
                nt = (par_q.size() != 0) ? par_q.pop_front() : '{1'b0, vin_level, cur_n};
                if (!nt.skip) check(result_data, nt.val, "parallel");
            end
            if (serial_clk === 1'b1 && sclk_prev === 1'b0) sreg = {sreg[14:0], serial_data};
            sclk_prev = serial_clk;
            if (cycle_end_count === 1'b1) begin
                nt = (ser_q.size() != 0) ? ser_q.pop_front() : '{1'b0, vin_level, cur_n};
                m = 16'((1 << ((nt.n != 0) ? nt.n : BASE_LENGTH)) - 1);
                if (!nt.skip) check(sreg & m, nt.val, "serial");
                if (!nt.skip && nt.n != 0) begin
                    check(16'(($time - last_t) / 100), 16'(2 * nt.n * STEP_CYCLES), "period");
                end
                last_t = $time;
            end
        end
    end
    initial begin
        #3_000_000;
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        results();
    end
endmodule // sar_adc_control_logic_bench
